/* File: verilog/flrs_pkg.sv */
package flrs_pkg;

   // bus geometry of one die
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 30;
   localparam int SYNC_STAGES = 2;

   // clock
   localparam int CLK_PERIOD_NS = 40;

   // pin timing, in the unit printed
   localparam int T_READY_ALG_NS  = 20000;
   localparam int T_READY_IDLE_NS = 500;
   localparam int T_RP_NS         = 500;
   localparam int T_RH_NS         = 50;
   localparam int T_RPD_NS        = 20000;
   localparam int T_ACC_NS        = 90;
   localparam int T_WP_NS         = 35;
   localparam int T_WPH_NS        = 30;
   localparam int T_OEPH_NS       = 20;
   localparam int T_BUSY_NS       = 90;
   localparam int T_RSP_US        = 4;
   localparam int T_RRB_US        = 4;
   localparam int T_ACCEL_US      = 7;
   localparam longint T_ERASE_TYP_MS = 1600;
   localparam longint T_ERASE_MAX_MS = 15000;

   function automatic int cyc_up(input longint ns);
      longint c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : int'(c);
   endfunction : cyc_up

   function automatic int cyc_dn(input longint ns);
      longint c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : int'(c);
   endfunction : cyc_dn

   // least times round up, longest times round down
   localparam int RP_CYC         = cyc_up(T_RP_NS);
   localparam int RH_CYC         = cyc_up(T_RH_NS);
   localparam int RPD_CYC        = cyc_up(T_RPD_NS);
   localparam int READY_ALG_CYC  = cyc_dn(T_READY_ALG_NS);
   localparam int READY_IDLE_CYC = cyc_dn(T_READY_IDLE_NS);
   localparam int ACC_CYC        = cyc_dn(T_ACC_NS);
   localparam int WP_CYC         = cyc_up(T_WP_NS);
   localparam int WPH_CYC        = cyc_up(T_WPH_NS);
   localparam int OEPH_CYC       = cyc_up(T_OEPH_NS);
   localparam int BUSY_CYC       = cyc_dn(T_BUSY_NS);
   localparam int RSP_CYC        = cyc_up(longint'(T_RSP_US) * 1000);
   localparam int RRB_CYC        = cyc_up(longint'(T_RRB_US) * 1000);
   localparam int ACCEL_TYP_CYC  = cyc_dn(longint'(T_ACCEL_US) * 1000);
   localparam int ERASE_TYP_CYC  = cyc_dn(T_ERASE_TYP_MS * 1000000);
   localparam int ERASE_MAX_CYC  = cyc_dn(T_ERASE_MAX_MS * 1000000);
   // read data passes the pin synchroniser after the access time
   localparam int RD_CYC         = ACC_CYC + SYNC_STAGES;

   // status and protect address bit positions
   localparam int MAIN_TOGGLE_POS    = 6;
   localparam int SUSPEND_TOGGLE_POS = 2;
   localparam int ADDR_SIX_POS       = 6;
   localparam int ADDR_ONE_POS       = 1;
   localparam int ADDR_ZERO_POS      = 0;

   typedef enum logic [3:0] {
      OP_READ, OP_POLL, OP_WRITE, OP_WRITE_LAST, OP_PROTECT,
      OP_UNPROTECT, OP_RESET, OP_STANDBY, OP_TU_ENTER, OP_TU_EXIT
   } flrs_op_t;

   typedef struct packed {
      flrs_op_t              op;
      logic                  die;
      logic                  boost;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     data;
   } flrs_req_t;

   typedef struct packed {
      logic [DATA_W-1:0]     data;
      logic                  main_toggled;
      logic                  suspend_toggled;
      logic                  timeout;
      logic                  over_typical;
   } flrs_rsp_t;

   typedef struct packed {
      logic                  ce_n;
      logic                  second_die_select_n;
      logic                  oe_n;
      logic                  we_n;
      logic                  reset_n;
      logic                  vid_en;
      logic                  program_boost_pin;
      logic [ADDR_W-1:0]     addr;
   } flrs_pins_t;

   localparam flrs_pins_t PINS_IDLE = '{ce_n: 1'b1,
      second_die_select_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
      vid_en: 1'b0, program_boost_pin: 1'b0, addr: '0};

endpackage : flrs_pkg

/* File: verilog/flrs_sync.sv */
`timescale 1ns/1ps
module flrs_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : flrs_sync

/* File: verilog/flrs_host.sv */
// Behaviour
// - wait 50 ns after reset release before any read.
// - toggle bits advance per read, framed by output or chip select.
// - protect uses address bit six low, bit one high, bit zero low.
// - unprotect uses address bit six high, bit one high, zero low.
// - hold elevated clear line 4 us before first write.
// - keep clear line elevated 4 us after busy output returns high.
`timescale 1ns/1ps
module flrs_host
   import flrs_pkg::*;
#(
   parameter int BUSY_TIMEOUT_CYC = ERASE_MAX_CYC,
   parameter int ERASE_TYP_LIM    = ERASE_TYP_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // request side
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire flrs_req_t         req,
   // answer side
   output logic                   rsp_valid,
   output flrs_rsp_t              rsp,
   // flash pins
   output flrs_pins_t             pins,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe_n,
   input  wire logic [DATA_W-1:0] dq_in,
   input  wire logic              ready_busy_n_out
);
   typedef enum logic [3:0] {
      S_IDLE, S_READ, S_POLL_GAP, S_WR_LOW, S_WR_HIGH, S_BUSY_DLY,
      S_BUSY, S_RST_LOW, S_RST_REC, S_TU_SETUP, S_TU_WAIT, S_TU_HOLD
   } flrs_state_t;

   flrs_state_t        st_q, st_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   flrs_req_t          req_q, req_d;
   flrs_pins_t         pins_q, pins_d;
   logic [DATA_W-1:0]  dq_q, dq_d;
   logic               dq_oe_n_q, dq_oe_n_d;
   flrs_rsp_t          rsp_q, rsp_d;
   logic               rsp_v_q, rsp_v_d;
   logic               alg_q, alg_d;
   logic               second_q, second_d;
   logic [1:0]         tog_q, tog_d;
   logic [DATA_W-1:0]  dq_s;
   logic               rb_s;
   logic [CNT_W-1:0]   cnt_inc;
   logic [CNT_W-1:0]   rst_low_lim;
   logic [CNT_W-1:0]   rec_lim;
   logic [CNT_W-1:0]   typ_lim;

   // pins come from another timing domain, so both pass two flops
   flrs_sync #(.W(DATA_W + 1)) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .d       ({ready_busy_n_out, dq_in}),
      .q       ({rb_s, dq_s})
   );

   assign cnt_inc     = cnt_q + CNT_W'(1);
   assign rst_low_lim = (req_q.op == OP_STANDBY) ?
                        CNT_W'(RPD_CYC - 1) : CNT_W'(RP_CYC - 1);
   // recovery covers the read-mode return after an aborted algorithm or from idle, plus the read gap
   assign rec_lim     = alg_q ? CNT_W'(READY_ALG_CYC + RH_CYC - 1)
                              : CNT_W'(READY_IDLE_CYC + RH_CYC - 1);
   assign typ_lim     = req_q.boost ? CNT_W'(ACCEL_TYP_CYC)
                                    : CNT_W'(ERASE_TYP_LIM);

   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      req_d     = req_q;
      pins_d    = pins_q;
      dq_d      = dq_q;
      dq_oe_n_d = dq_oe_n_q;
      rsp_d     = rsp_q;
      rsp_v_d   = 1'b0;
      alg_d     = alg_q;
      second_d  = second_q;
      tog_d     = tog_q;
      case (st_q)
         S_IDLE: begin
            if (req_valid) begin
               req_d    = req;
               rsp_d    = '0;
               cnt_d    = '0;
               second_d = 1'b0;
               pins_d.addr = req.addr;
               case (req.op)
                  OP_READ, OP_POLL: begin
                     pins_d.ce_n                = req.die;
                     pins_d.second_die_select_n = ~req.die;
                     pins_d.oe_n                = 1'b0;
                     st_d                       = S_READ;
                  end
                  OP_WRITE, OP_WRITE_LAST, OP_PROTECT, OP_UNPROTECT: begin
                     pins_d.ce_n                = req.die;
                     pins_d.second_die_select_n = ~req.die;
                     pins_d.we_n                = 1'b0;
                     pins_d.program_boost_pin   = req.boost;
                     dq_d                       = req.data;
                     dq_oe_n_d                  = 1'b0;
                     if (req.op == OP_PROTECT) begin
                        pins_d.addr[ADDR_SIX_POS]  = 1'b0;
                        pins_d.addr[ADDR_ONE_POS]  = 1'b1;
                        pins_d.addr[ADDR_ZERO_POS] = 1'b0;
                     end else if (req.op == OP_UNPROTECT) begin
                        pins_d.addr[ADDR_SIX_POS]  = 1'b1;
                        pins_d.addr[ADDR_ONE_POS]  = 1'b1;
                        pins_d.addr[ADDR_ZERO_POS] = 1'b0;
                     end
                     st_d = S_WR_LOW;
                  end
                  OP_RESET, OP_STANDBY: begin
                     // a low busy line means an algorithm must be aborted
                     alg_d          = ~rb_s;
                     pins_d.reset_n = 1'b0;
                     pins_d.vid_en  = 1'b0;
                     st_d           = S_RST_LOW;
                  end
                  OP_TU_ENTER: begin
                     pins_d.vid_en = 1'b1;
                     st_d          = S_TU_SETUP;
                  end
                  OP_TU_EXIT: begin
                     st_d = S_TU_WAIT;
                  end
                  default: begin
                     rsp_v_d = 1'b1;
                  end
               endcase
            end
         end
         S_READ: begin
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(RD_CYC - 1)) begin
               cnt_d       = '0;
               pins_d.oe_n = 1'b1;
               // any address works for the main toggle bit
               if (req_q.op == OP_POLL && !second_q) begin
                  tog_d    = {dq_s[MAIN_TOGGLE_POS],
                              dq_s[SUSPEND_TOGGLE_POS]};
                  second_d = 1'b1;
                  st_d     = S_POLL_GAP;
               end else begin
                  rsp_d.data = dq_s;
                  if (req_q.op == OP_POLL) begin
                     // a busy die answers with status bits
                     rsp_d.main_toggled    =
                        dq_s[MAIN_TOGGLE_POS] ^ tog_q[1];
                     rsp_d.suspend_toggled =
                        dq_s[SUSPEND_TOGGLE_POS] ^ tog_q[0];
                  end
                  pins_d.ce_n                = 1'b1;
                  pins_d.second_die_select_n = 1'b1;
                  rsp_v_d                    = 1'b1;
                  st_d                       = S_IDLE;
               end
            end
         end
         S_POLL_GAP: begin
            // chip select stays low; output gate alone frames each read
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(OEPH_CYC - 1)) begin
               cnt_d       = '0;
               pins_d.oe_n = 1'b0;
               st_d        = S_READ;
            end
         end
         S_WR_LOW: begin
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(WP_CYC - 1)) begin
               cnt_d       = '0;
               pins_d.we_n = 1'b1;
               st_d        = S_WR_HIGH;
            end
         end
         S_WR_HIGH: begin
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(WPH_CYC - 1)) begin
               cnt_d                      = '0;
               dq_oe_n_d                  = 1'b1;
               pins_d.ce_n                = 1'b1;
               pins_d.second_die_select_n = 1'b1;
               if (req_q.op == OP_WRITE) begin
                  rsp_v_d = 1'b1;
                  st_d    = S_IDLE;
               end else begin
                  st_d = S_BUSY_DLY;
               end
            end
         end
         S_BUSY_DLY: begin
            // busy may lag the last write; do not read it early
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(BUSY_CYC + SYNC_STAGES - 1)) begin
               cnt_d = '0;
               st_d  = S_BUSY;
            end
         end
         S_BUSY: begin
            cnt_d = cnt_inc;
            if (rb_s || cnt_q == CNT_W'(BUSY_TIMEOUT_CYC - 1)) begin
               rsp_d.timeout            = ~rb_s;
               rsp_d.over_typical       = cnt_q > typ_lim;
               pins_d.program_boost_pin = 1'b0;
               cnt_d                    = '0;
               rsp_v_d                  = 1'b1;
               st_d                     = S_IDLE;
            end
         end
         S_RST_LOW: begin
            cnt_d = cnt_inc;
            if (cnt_q == rst_low_lim) begin
               cnt_d          = '0;
               pins_d.reset_n = 1'b1;
               st_d           = S_RST_REC;
            end
         end
         S_RST_REC: begin
            cnt_d = cnt_inc;
            if (cnt_q == rec_lim) begin
               cnt_d   = '0;
               rsp_v_d = 1'b1;
               st_d    = S_IDLE;
            end
         end
         S_TU_SETUP: begin
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(RSP_CYC - 1)) begin
               cnt_d   = '0;
               rsp_v_d = 1'b1;
               st_d    = S_IDLE;
            end
         end
         S_TU_WAIT: begin
            // no timeout: a stuck busy line keeps the voltage applied
            if (rb_s) begin
               cnt_d = '0;
               st_d  = S_TU_HOLD;
            end
         end
         S_TU_HOLD: begin
            cnt_d = cnt_inc;
            if (cnt_q == CNT_W'(RRB_CYC - 1)) begin
               cnt_d         = '0;
               pins_d.vid_en = 1'b0;
               rsp_v_d       = 1'b1;
               st_d          = S_IDLE;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q      <= S_IDLE;
         cnt_q     <= '0;
         req_q     <= '0;
         pins_q    <= PINS_IDLE;
         dq_q      <= '0;
         dq_oe_n_q <= 1'b1;
         rsp_q     <= '0;
         rsp_v_q   <= 1'b0;
         alg_q     <= 1'b0;
         second_q  <= 1'b0;
         tog_q     <= '0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         req_q     <= req_d;
         pins_q    <= pins_d;
         dq_q      <= dq_d;
         dq_oe_n_q <= dq_oe_n_d;
         rsp_q     <= rsp_d;
         rsp_v_q   <= rsp_v_d;
         alg_q     <= alg_d;
         second_q  <= second_d;
         tog_q     <= tog_d;
      end
   end

   assign req_ready = (st_q == S_IDLE);
   assign rsp_valid = rsp_v_q;
   assign rsp       = rsp_q;
   assign pins      = pins_q;
   assign dq_out    = dq_q;
   assign dq_oe_n   = dq_oe_n_q;
endmodule : flrs_host

/* File: bench/flrs_host_assertions.sv */
`timescale 1ns/1ps
module flrs_host_assertions
   import flrs_pkg::*;
#(
   parameter int BUSY_TIMEOUT_CYC = 200,
   parameter int ERASE_TYP_LIM    = 50
) (
   // clock and reset
   input wire logic              clk_sys,
   input wire logic              reset,
   // request and answer
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire flrs_req_t         req,
   input wire logic              rsp_valid,
   input wire flrs_rsp_t         rsp,
   // flash pins
   input wire flrs_pins_t        pins,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe_n,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic              ready_busy_n_out
);
   flrs_op_t    op_q, op_d;
   logic        die_q, die_d;
   logic [15:0] low_q, low_d, vid_q, vid_d, rdy_q, rdy_d;
   logic        take;
   // run lengths count samples before the current edge
   always_comb begin
      take  = req_valid && req_ready;
      op_d  = take ? req.op : op_q;
      die_d = take ? req.die : die_q;
      low_d = pins.reset_n ? 16'h0 : low_q + 16'h1;
      vid_d = pins.vid_en ? vid_q + 16'h1 : 16'h0;
      rdy_d = ready_busy_n_out ? rdy_q + 16'h1 : 16'h0;
   end
   always_ff @(posedge clk_sys) begin
      op_q  <= reset ? OP_READ : op_d;
      die_q <= reset ? 1'b0 : die_d;
      low_q <= reset ? 16'h0 : low_d;
      vid_q <= reset ? 16'h0 : vid_d;
      rdy_q <= reset ? 16'h0 : rdy_d;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_take_rd;
      take && req.op == OP_READ;
   endsequence
   sequence s_rd_done;
      ##5 rsp_valid;
   endsequence
   idle_after_reset_a:
      assert property (disable iff (1'b0) reset |=> pins == PINS_IDLE
         && dq_oe_n && !rsp_valid) else $error("pins not idle");
   reset_width_a:
      assert property ($rose(pins.reset_n) |-> low_q >= 16'(RP_CYC))
         else $error("reset pulse short");
   read_gap_a:
      assert property ($rose(pins.reset_n) |-> pins.oe_n [*2])
         else $error("read too soon after reset");
   busy_blind_a:
      assert property ($rose(pins.we_n) && op_q == OP_WRITE_LAST
         |-> !rsp_valid [*3]) else $error("busy not awaited");
   protect_addr_a:
      assert property (!pins.we_n && op_q == OP_PROTECT |-> !pins.addr[6]
         && pins.addr[1] && !pins.addr[0]) else $error("protect addr");
   unprotect_addr_a:
      assert property (!pins.we_n && op_q == OP_UNPROTECT |-> pins.addr[6]
         && pins.addr[1] && !pins.addr[0]) else $error("unprotect addr");
   die_select_a:
      assert property (!pins.ce_n || !pins.second_die_select_n
         |-> pins.ce_n == die_q && pins.second_die_select_n != die_q)
         else $error("wrong die selected");
   tu_setup_a:
      assert property (!pins.we_n && pins.vid_en |-> vid_q >= 16'(RSP_CYC))
         else $error("write too soon after raise");
   tu_release_a:
      assert property ($fell(pins.vid_en) && op_q == OP_TU_EXIT
         |-> rdy_q >= 16'(RRB_CYC)) else $error("line dropped early");
   read_answer_a:
      assert property (s_take_rd |-> s_rd_done)
         else $error("read answer late");
   poll_frame_a:
      assert property ($rose(pins.oe_n) && op_q == OP_POLL && (!pins.ce_n
         || !pins.second_die_select_n) |=> !pins.oe_n)
         else $error("poll gap wrong");
   read_no_drive_a:
      assert property (!pins.oe_n |-> dq_oe_n)
         else $error("data bus driven during read");
   write_drive_a:
      assert property (!pins.we_n |-> !dq_oe_n)
         else $error("write data not driven");
endmodule : flrs_host_assertions
bind flrs_host flrs_host_assertions #(
   .BUSY_TIMEOUT_CYC(BUSY_TIMEOUT_CYC), .ERASE_TYP_LIM(ERASE_TYP_LIM)
) u_chk (.clk_sys, .reset, .req_valid, .req_ready, .req, .rsp_valid,
   .rsp, .pins, .dq_out, .dq_oe_n, .dq_in, .ready_busy_n_out);

/* File: bench/flrs_flash_model.sv */
`timescale 1ns/1ps
module flrs_flash_model
   import flrs_pkg::*;
#(
   parameter int                BUSY_LEN  = 100,
   parameter int                ACCEL_LEN = 60,
   parameter logic [DATA_W-1:0] START     = 16'h0030
) (
   // clock
   input  wire logic              clk_sys,
   // host side
   input  wire flrs_pins_t        pins,
   input  wire logic [DATA_W-1:0] dq_out,
   input  wire logic              dq_oe_n,
   // device side
   output logic [DATA_W-1:0]      dq_in,
   output logic                   ready_busy_n_out
);
   int                busy [2] = '{0, 0};
   logic [1:0]        sel, rd, rd_q = '0, t6 = '0, t2 = '0, we_q = '0;
   logic [DATA_W-1:0] noise = 16'hA5A5;
   int                low = 0;
   logic              standby, sus, sus_q = 1'b0;
   assign sel = {~pins.second_die_select_n, ~pins.ce_n};
   assign rd  = sel & {2{~pins.oe_n}};
   assign sus = pins.addr[ADDR_W-1];
   // open drain with pull-up: either busy die pulls it low
   assign ready_busy_n_out = busy[0] == 0 && busy[1] == 0;
   // a released bus shows a pattern that changes every cycle
   always_comb begin
      dq_in = noise;
      for (int d = 0; d < 2; d++)
         if (rd[d])
            if (busy[d] != 0 || sus)
               dq_in = {9'h0, t6[d], 3'h0, t2[d], 2'h0};
            else
               dq_in = pins.addr[15:0] ^ (d ? 16'h00FF : 16'h5A5A);
   end
   always @(posedge clk_sys) begin
      noise   <= ~noise;
      rd_q    <= rd;
      we_q    <= sel & {2{~pins.we_n}};
      low     <= pins.reset_n ? 0 : low + 1;
      // low lags by one edge, so count the current low sample too
      standby <= !pins.reset_n && low + 1 >= RPD_CYC;
      if (|rd)
         sus_q <= sus;
      for (int d = 0; d < 2; d++) begin
         if (rd_q[d] && !rd[d]) begin
            t6[d] <= (busy[d] != 0) ^ t6[d];
            t2[d] <= sus_q ^ t2[d];
         end
         if (!pins.reset_n)
            busy[d] <= 0;
         else if (busy[d] != 0)
            busy[d] <= busy[d] - 1;
         else if (we_q[d] && pins.we_n && dq_out == START)
            busy[d] <= pins.program_boost_pin ? ACCEL_LEN : BUSY_LEN;
      end
   end
endmodule : flrs_flash_model

/* File: bench/flrs_host_tb.sv */
`timescale 1ns/1ps
module flrs_host_tb
   import flrs_pkg::*;
;
   localparam int                BL = 100;
   localparam int                AL = 60;
   localparam logic [DATA_W-1:0] GO = 16'h0030;
   logic              clk_sys, reset, req_valid, req_ready, rsp_valid;
   logic              dq_oe_n, ready_busy_n_out;
   flrs_req_t         req;
   flrs_rsp_t         rsp;
   flrs_pins_t        pins;
   logic [DATA_W-1:0] dq_out, dq_in;
   logic [ADDR_W-1:0] we_addr;
   int                miscompares = 0, comparisons = 0;
   int                lat, run = 0, low_run = 0;
   logic              stby_seen = 1'b0;
   flrs_host #(.BUSY_TIMEOUT_CYC(200), .ERASE_TYP_LIM(50)) dut (.clk_sys,
      .reset, .req_valid, .req_ready, .req, .rsp_valid, .rsp, .pins,
      .dq_out, .dq_oe_n, .dq_in, .ready_busy_n_out);
   flrs_flash_model #(.BUSY_LEN(BL), .ACCEL_LEN(AL), .START(GO)) u_flash (
      .clk_sys, .pins, .dq_out, .dq_oe_n, .dq_in, .ready_busy_n_out);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // sampled mid-cycle, away from the edge that moves the pins
   always @(negedge clk_sys) begin
      run <= pins.reset_n ? 0 : run + 1;
      if (!pins.reset_n)
         low_run <= run + 1;
      if (!pins.we_n)
         we_addr <= pins.addr;
      if (u_flash.standby)
         stby_seen <= 1'b1;
   end
   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic bad(input string n, input string e, input string g);
      miscompares++;
      $display("MISMATCH %s expected %s seen %s", n, e, g);
   endtask : bad
   task automatic chk16(input string n, input logic [15:0] e,
                        input logic [15:0] g);
      comparisons++;
      if (g !== e)
         bad(n, $sformatf("%h", e), $sformatf("%h", g));
   endtask : chk16
   task automatic chk_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e)
         bad(n, $sformatf("%b", e), $sformatf("%b", g));
   endtask : chk_bit
   task automatic chk_min(input string n, input int lo, input int g);
      comparisons++;
      if (g < lo)
         bad(n, $sformatf(">=%0d", lo), $sformatf("%0d", g));
   endtask : chk_min
   // offers one op at a falling edge and waits, bounded, for its answer
   task automatic do_op(input flrs_op_t op, input logic die, boost,
                        input logic [ADDR_W-1:0] a, input logic [15:0] d);
      for (int n = 0; n < 100 && req_ready !== 1'b1; n++)
         @(negedge clk_sys);
      if (req_ready !== 1'b1) begin
         bad("ready", "1", "0");
         end_sim();
      end
      req_valid = 1'b1;
      req = '{op: op, die: die, boost: boost, addr: a, data: d};
      @(negedge clk_sys);
      req_valid = 1'b0;
      for (lat = 1; lat < 2000 && rsp_valid !== 1'b1; lat++)
         @(negedge clk_sys);
      if (rsp_valid !== 1'b1) begin
         bad("answer", "1", "0");
         end_sim();
      end
   endtask : do_op
   task automatic s_read;
      for (int d = 0; d < 2; d++) begin
         do_op(OP_READ, d[0], 1'b0, 22'h001234, '0);
         chk16("read", 16'h1234 ^ (d ? 16'h00FF : 16'h5A5A), rsp.data);
      end
   endtask : s_read
   task automatic s_poll;
      do_op(OP_WRITE, 1'b0, 1'b0, 22'h000100, GO);
      do_op(OP_POLL, 1'b0, 1'b0, 22'h000777, '0);
      chk_bit("main toggle", 1'b1, rsp.main_toggled);
      chk_bit("suspend toggle", 1'b0, rsp.suspend_toggled);
      chk16("status", 16'h0, rsp.data & 16'hFFBB);
      do_op(OP_POLL, 1'b1, 1'b0, 22'h000777, '0);
      chk_bit("idle die toggle", 1'b0, rsp.main_toggled);
      do_op(OP_POLL, 1'b0, 1'b0, 22'h200000, '0);
      chk_bit("suspend toggle", 1'b1, rsp.suspend_toggled);
      do_op(OP_RESET, 1'b0, 1'b0, '0, '0);
      do_op(OP_READ, 1'b0, 1'b0, 22'h000010, '0);
      chk16("read after abort", 16'h5A4A, rsp.data);
   endtask : s_poll
   task automatic s_erase;
      do_op(OP_WRITE_LAST, 1'b0, 1'b0, 22'h000100, GO);
      chk_min("erase cycles", BL, lat);
      chk_bit("over typical", 1'b1, rsp.over_typical);
      chk_bit("timeout", 1'b0, rsp.timeout);
      do_op(OP_WRITE_LAST, 1'b1, 1'b1, 22'h000100, GO);
      chk_min("boost cycles", AL, lat);
      chk_bit("boost over typical", 1'b0, rsp.over_typical);
   endtask : s_erase
   task automatic s_reset;
      int ans_min = 1 + RP_CYC + READY_IDLE_CYC + RH_CYC;
      do_op(OP_RESET, 1'b0, 1'b0, '0, '0);
      chk_min("reset low", RP_CYC, low_run);
      chk_min("reset answer", ans_min, lat);
      chk_bit("short reset standby", 1'b0, stby_seen);
      do_op(OP_STANDBY, 1'b0, 1'b0, '0, '0);
      chk_min("standby low", RPD_CYC, low_run);
      chk_bit("standby entered", 1'b1, stby_seen);
   endtask : s_reset
   task automatic s_protect;
      do_op(OP_PROTECT, 1'b0, 1'b0, 22'h00007D, '0);
      chk16("protect addr", 16'h0002, {9'h0, we_addr[6:0] & 7'h43});
      do_op(OP_UNPROTECT, 1'b0, 1'b0, 22'h000000, '0);
      chk16("unprot addr", 16'h0042, {9'h0, we_addr[6:0] & 7'h43});
   endtask : s_protect
   task automatic s_tu;
      do_op(OP_TU_ENTER, 1'b0, 1'b0, '0, '0);
      chk_min("raise setup", RSP_CYC, lat);
      do_op(OP_WRITE_LAST, 1'b0, 1'b0, 22'h000100, GO);
      do_op(OP_TU_EXIT, 1'b0, 1'b0, '0, '0);
      chk_min("raise hold", RRB_CYC, lat);
      chk_bit("raised line", 1'b0, pins.vid_en);
   endtask : s_tu
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      s_read();
      s_poll();
      s_erase();
      s_reset();
      s_protect();
      s_tu();
      end_sim();
   end
endmodule : flrs_host_tb
